// [include/iopc_pkg.sv]
/*
 I/O pad configuration and wake-up block: register offsets, field
 positions, reset values and port geometry.
 Assumes an 8-bit register port with 8-bit addresses.
*/
package iopc_pkg;
   localparam int NPORT = 6;               // ports A..F
   localparam int PA = 0;
   localparam int PB = 1;
   localparam int PC = 2;
   localparam int PD = 3;
   localparam int PE = 4;
   localparam int PF = 5;

   // register offsets
   localparam logic [7:0] OFS_DATA0    = 8'h00;  // data A..F at 0x00..0x05
   localparam logic [7:0] OFS_DIR0     = 8'h08;  // direction A..F 0x08..0x0D
   localparam logic [7:0] OFS_EDGE     = 8'h10;
   localparam logic [7:0] OFS_SUPLO    = 8'h11;
   localparam logic [7:0] OFS_SUPHI    = 8'h12;
   localparam logic [7:0] OFS_WAKEA    = 8'h13;
   localparam logic [7:0] OFS_WAKEF    = 8'h14;
   localparam logic [7:0] OFS_WAKENIB  = 8'h15;
   localparam logic [7:0] OFS_INTSTAT  = 8'h16;
   localparam logic [7:0] OFS_INTMASK  = 8'h17;
   localparam logic [7:0] OFS_SLEEP    = 8'h18;
   localparam logic [7:0] OFS_BITOP    = 8'h19;

   // edge-rate field positions
   localparam int EDGE_A_LO = 0;
   localparam int EDGE_B_LO = 2;
   localparam int EDGE_C_LO = 4;
   localparam int EDGE_D_LO = 6;
   localparam logic [1:0] EDGE_200NS = 2'h0;
   localparam logic [1:0] EDGE_100NS = 2'h1;
   localparam logic [1:0] EDGE_50NS  = 2'h2;
   localparam logic [1:0] EDGE_NONE  = 2'h3;

   // supply codes
   localparam logic [1:0] RAIL_MAIN = 2'h0;
   localparam logic [1:0] RAIL_IO   = 2'h2;
   localparam logic [1:0] RAIL_3V3  = 2'h3;

   // reset values
   localparam logic [7:0] RST_PORT = 8'hFF;
   localparam logic [7:0] RST_CFG  = 8'h00;

   // input-only pin
   localparam int PE_IN_ONLY = 1;

   // bit-operation register layout: [7] set/clear, [6] dir/data,
   // [5:3] port, [2:0] bit
   localparam int BOP_SET  = 7;
   localparam int BOP_DIR  = 6;
   localparam int BOP_PH   = 5;
   localparam int BOP_PL   = 3;
   localparam int BOP_BH   = 2;

   // interrupt status layout
   localparam int IRQ_WAKE = 0;

   // selects the nibble enable index (0..7) for ports B..E
   localparam int NIB_B = 0;
endpackage

// [rtl/iopc_io_pad_config.sv]
/*
 I/O pad configuration and wake-up logic: port data and direction,
 edge-rate selects, port A supply selects, falling-edge wake-up with a
 sticky interrupt status.
 Assumes pad inputs synchronous to mclk and a single-master register
 port with one-cycle strobes and read data one cycle later.
*/
`timescale 1ns/1ps

// What this block does
// R1: port A edge-rate code in bits 1..0: 200ns, 100ns, 50ns, unlimited.
// R2: port B edge-rate code in bits 3..2, same encoding.
// R3: port D edge-rate code in bits 7..6, same encoding.
// R4: port C edge-rate in bits 5..4 on large parts, else reads zero.
// R5: port A pins 0..3 supply select, two bits per pin, first register.
// R6: port A pins 4..7 supply select, two bits per pin, second register.
// R7: reset sets every data and direction bit to one.
// R8: an output pin drives its held data bit.
// R9: single-bit set or clear rewrites whole port byte read back.
// R10: wake enable per pin on ports A and F, per nibble on B..E.
// R11: while asleep, falling edge on wake-enabled pin wakes device.
// R12: port E pin 1 is input only, no pull-up, no wake-up.
// R13: direction bit 0 means output, 1 means input.
// R14: ports E and F are fixed at the 200ns edge rate.
// R15: edge-rate and supply fields reset to 00.
module iopc_io_pad_config
   import iopc_pkg::*;
#(
   parameter bit HAS_PORT_C_EDGE = 1'b1
)(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdata,
   input  wire logic [47:0] padIn,
   output logic      [47:0] padOut,
   output logic      [47:0] padOe_n,
   output logic      [11:0] padEdgeRate,
   output logic      [15:0] padRailSel,
   output logic             wakeUp,
   output logic             irq
);

   logic [7:0]  data_q    [NPORT];
   logic [7:0]  dir_q     [NPORT];
   logic [7:0]  edgeSel_q;
   logic [7:0]  supLo_q;
   logic [7:0]  supHi_q;
   logic [7:0]  wakeA_q;
   logic [7:0]  wakeF_q;
   logic [7:0]  wakeNib_q;
   logic [7:0]  stat_q;
   logic [7:0]  mask_q;
   logic        sleep_q;
   logic [47:0] padPrev_q;
   logic [7:0]  stat_d;
   logic        sleep_d;
   logic [47:0] wakeEn;
   logic [47:0] fallHit;
   logic        wakeEvt;
   logic [7:0]  edgeRead;
   logic [7:0]  rdMux;

   // true when addr selects a port register at base
   function automatic logic isPort(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input int p);
      return a == base + 8'(p);
   endfunction

   // true when a write strobe hits the given offset
   function automatic logic wrAt(input logic       wr,
                                 input logic [7:0] a,
                                 input logic [7:0] ofs);
      return wr && (a == ofs);
   endfunction

   // R9: byte read from the port, one bit changed, written back
   function automatic logic [7:0] bitOp(input logic [7:0] cur,
                                        input logic [7:0] op);
      logic [7:0] m;
      m = 8'h01 << op[BOP_BH:0];
      return op[BOP_SET] ? (cur | m) : (cur & ~m);
   endfunction

   // R7: every port register comes out of reset all ones
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic [2:0] opPort;
      logic       opHit;
      assign opPort = regWdata[BOP_PH:BOP_PL];
      assign opHit  = wrAt(regWr, regAddr, OFS_BITOP) && (opPort == 3'(p));

      // R13: direction byte write or bit op on the register itself
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            dir_q[p] <= RST_PORT;
         end else if (regWr && isPort(regAddr, OFS_DIR0, p)) begin
            dir_q[p] <= regWdata;
         end else if (opHit && regWdata[BOP_DIR]) begin
            dir_q[p] <= bitOp(dir_q[p], regWdata);
         end
      end

      // R8: data byte write or bit op on the levels at the pads
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            data_q[p] <= RST_PORT;
         end else if (regWr && isPort(regAddr, OFS_DATA0, p)) begin
            data_q[p] <= regWdata;
         end else if (opHit && !regWdata[BOP_DIR]) begin
            // R9: whole port read from the pads; a pin held low from
            // outside is written back low
            data_q[p] <= bitOp(padIn[p*8 +: 8], regWdata);
         end
      end
   end

   // R1: edge-rate codes of ports A..D share one byte
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // R15: 200ns on every port after reset
         edgeSel_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_EDGE)) begin
         edgeSel_q <= regWdata;
      end
   end

   // R5: supply select of port A pins 0..3
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // R15: main supply after reset
         supLo_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_SUPLO)) begin
         supLo_q <= regWdata;
      end
   end

   // R6: supply select of port A pins 4..7
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // R15: main supply after reset
         supHi_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_SUPHI)) begin
         supHi_q <= regWdata;
      end
   end

   // R10: per-pin wake enables of port A
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wakeA_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_WAKEA)) begin
         wakeA_q <= regWdata;
      end
   end

   // R10: per-pin wake enables of port F
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wakeF_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_WAKEF)) begin
         wakeF_q <= regWdata;
      end
   end

   // R10: one enable per nibble of ports B..E
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wakeNib_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_WAKENIB)) begin
         wakeNib_q <= regWdata;
      end
   end

   // interrupt mask, same layout as the status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mask_q <= RST_CFG;
      end else if (wrAt(regWr, regAddr, OFS_INTMASK)) begin
         mask_q <= regWdata;
      end
   end

   // R11: a wake event ends sleep, even beside a sleep write
   always_comb begin
      sleep_d = sleep_q;
      if (wakeEvt) begin
         sleep_d = 1'b0;
      end else if (wrAt(regWr, regAddr, OFS_SLEEP)) begin
         sleep_d = regWdata[0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_d;
      end
   end

   // R10: per-pin on A and F, per nibble on B..E
   always_comb begin
      wakeEn = '0;
      wakeEn[PA*8 +: 8] = wakeA_q;
      wakeEn[PF*8 +: 8] = wakeF_q;
      for (int n = 0; n < 8; n++) begin
         wakeEn[PB*8 + n*4 +: 4] = {4{wakeNib_q[NIB_B + n]}};
      end
      // R12: no wake-up on the input-only pin
      wakeEn[PE*8 + PE_IN_ONLY] = 1'b0;
   end

   // R11: falling edge on an enabled pin while asleep
   assign fallHit = padPrev_q & ~padIn & wakeEn;
   assign wakeEvt = sleep_q && (|fallHit);

   // previous levels start low so that reset never fakes a falling edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padPrev_q <= '0;
      end else begin
         padPrev_q <= padIn;
      end
   end

   // sticky status, write one to clear; an event in the same cycle wins
   always_comb begin
      stat_d = stat_q;
      if (wrAt(regWr, regAddr, OFS_INTSTAT)) begin
         stat_d = stat_q & ~regWdata;
      end
      if (wakeEvt) begin
         stat_d[IRQ_WAKE] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stat_q <= RST_CFG;
      end else begin
         stat_q <= stat_d;
      end
   end

   // R4: port C field absent on small parts, reads zero
   always_comb begin
      edgeRead = edgeSel_q;
      if (!HAS_PORT_C_EDGE) begin
         edgeRead[EDGE_C_LO +: 2] = 2'h0;
      end
   end

   // unmapped offsets and the write-only bit-op register read zero
   always_comb begin
      rdMux = 8'h00;
      for (int p = 0; p < NPORT; p++) begin
         if (isPort(regAddr, OFS_DATA0, p)) begin
            rdMux = data_q[p];
         end
         if (isPort(regAddr, OFS_DIR0, p)) begin
            rdMux = dir_q[p];
         end
      end
      case (regAddr)
         OFS_EDGE:    rdMux = edgeRead;
         OFS_SUPLO:   rdMux = supLo_q;
         OFS_SUPHI:   rdMux = supHi_q;
         OFS_WAKEA:   rdMux = wakeA_q;
         OFS_WAKEF:   rdMux = wakeF_q;
         OFS_WAKENIB: rdMux = wakeNib_q;
         OFS_INTSTAT: rdMux = stat_q;
         OFS_INTMASK: rdMux = mask_q;
         OFS_SLEEP:   rdMux = {7'h00, sleep_q};
         default: ;
      endcase
   end

   // read data follow the strobe by one cycle, then hold
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         regRdata <= rdMux;
      end
   end

   // R8: output pins drive the held data level
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padOut <= '1;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            padOut[p*8 +: 8] <= data_q[p];
         end
      end
   end

   // R13: direction 0 enables the low-active driver
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padOe_n <= '1;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            padOe_n[p*8 +: 8] <= dir_q[p];
         end
         // R12: no driver on the input-only pin
         padOe_n[PE*8 + PE_IN_ONLY] <= 1'b1;
      end
   end

   // R1: edge codes to the pads, two bits per port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padEdgeRate <= '0;
      end else begin
         padEdgeRate[1:0] <= edgeSel_q[EDGE_A_LO +: 2];
         // R2: port B code
         padEdgeRate[3:2] <= edgeSel_q[EDGE_B_LO +: 2];
         // R4: port C code, zero on small parts
         padEdgeRate[5:4] <= edgeRead[EDGE_C_LO +: 2];
         // R3: port D code
         padEdgeRate[7:6] <= edgeSel_q[EDGE_D_LO +: 2];
         // R14: ports E and F fixed at 200ns
         padEdgeRate[9:8]   <= EDGE_200NS;
         padEdgeRate[11:10] <= EDGE_200NS;
      end
   end

   // R5: rail selects to the pads, pin n at bits 2n+1..2n
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         padRailSel <= '0;
      end else begin
         padRailSel <= {supHi_q, supLo_q};
      end
   end

   // R11: one-cycle wake pulse to the power controller
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wakeUp <= 1'b0;
      end else begin
         wakeUp <= wakeEvt;
      end
   end

   // level interrupt while an unmasked status bit is set
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

endmodule

// [dv/iopc_pad_partner.sv]
/*
 External circuitry on the pads: a pad that the block drives shows the
 driven level, a released pad shows the level set by the bench.
 Assumes active-low enables from the block and one clock domain.
*/
`timescale 1ns/1ps
module iopc_pad_partner (
   input  wire logic [47:0] padOut,
   input  wire logic [47:0] padOe_n,
   input  wire logic [47:0] extLevel,
   output logic      [47:0] padIn
);
   // released pads never echo the last driven value
   assign padIn = (padOut & ~padOe_n) | (extLevel & padOe_n);
endmodule

// [dv/iopc_io_pad_config_properties.sv]
/*
 Port-level properties of the pad configuration block.
 Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ps
module iopc_io_pad_config_properties
   import iopc_pkg::*;
#(
   parameter bit HAS_PORT_C_EDGE = 1'b1
)(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [7:0]  regAddr,
   input wire logic [7:0]  regWdata,
   input wire logic        regWr,
   input wire logic [47:0] padIn,
   input wire logic [47:0] padOut,
   input wire logic [47:0] padOe_n,
   input wire logic [11:0] padEdgeRate,
   input wire logic [15:0] padRailSel,
   input wire logic        wakeUp
);
   logic [47:0] prevIn_q;
   logic        fellAny;
   logic [7:0]  edgeMask;
   always_ff @(posedge mclk) prevIn_q <= padIn;
   assign fellAny  = |(prevIn_q & ~padIn);
   assign edgeMask = {2'h3, {2{HAS_PORT_C_EDGE}}, 4'hF};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_inOnly; padOe_n[33]; endproperty
   a_inOnly: assert property (p_inOnly)
      else $error("input-only pad enabled");
   property p_rstPort;
      disable iff (1'b0) !rst_n |=> padOut == '1 && padOe_n == '1;
   endproperty
   a_rstPort: assert property (p_rstPort)
      else $error("pads not inputs after reset");
   property p_rstCfg;
      disable iff (1'b0) !rst_n |=> padEdgeRate == '0 && padRailSel == '0;
   endproperty
   a_rstCfg: assert property (p_rstCfg)
      else $error("config not cleared by reset");
   property p_edge;
      regWr && regAddr == OFS_EDGE ##1 1'b1
         |=> padEdgeRate[7:0] == ($past(regWdata, 2) & edgeMask);
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge rate pads wrong");
   property p_fixedEdge; padEdgeRate[11:8] == 4'h0; endproperty
   a_fixedEdge: assert property (p_fixedEdge)
      else $error("ports E F edge rate not fixed");
   property p_railLo;
      regWr && regAddr == OFS_SUPLO ##1 1'b1
         |=> padRailSel[7:0] == $past(regWdata, 2);
   endproperty
   a_railLo: assert property (p_railLo)
      else $error("low rail select wrong");
   property p_railHi;
      regWr && regAddr == OFS_SUPHI ##1 1'b1
         |=> padRailSel[15:8] == $past(regWdata, 2);
   endproperty
   a_railHi: assert property (p_railHi)
      else $error("high rail select wrong");
   property p_data;
      regWr && regAddr == OFS_DATA0 ##1 1'b1
         |=> padOut[7:0] == $past(regWdata, 2);
   endproperty
   a_data: assert property (p_data)
      else $error("port A level wrong");
   property p_dir;
      regWr && regAddr == OFS_DIR0 ##1 1'b1
         |=> padOe_n[7:0] == $past(regWdata, 2);
   endproperty
   a_dir: assert property (p_dir)
      else $error("port A enables wrong");
   property p_wake; wakeUp |-> $past(fellAny); endproperty
   a_wake: assert property (p_wake)
      else $error("wake without falling pad");
endmodule

bind iopc_io_pad_config iopc_io_pad_config_properties #(
   .HAS_PORT_C_EDGE(HAS_PORT_C_EDGE)
) u_props (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .padIn(padIn), .padOut(padOut),
   .padOe_n(padOe_n), .padEdgeRate(padEdgeRate),
   .padRailSel(padRailSel), .wakeUp(wakeUp));

// [dv/test_io_pad_config_and_wakeup.sv]
/*
 Self-checking bench for the pad configuration block.
 Assumes the partner model drives every released pad.
*/
`timescale 1ns/1ps
module test_io_pad_config_and_wakeup;
   import iopc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [47:0] extLevel = '1;
   logic [7:0]  regRdata;
   logic [47:0] padIn, padOut, padOe_n;
   logic [11:0] padEdgeRate;
   logic [15:0] padRailSel;
   logic        wakeUp, irq;
   logic [7:0]  v;
   int          nErrors = 0;
   int          testsRun = 0;
   int          cycles = 0;
   int          seed = 32'he7ec52e1;
   localparam bit HAS_C = 1'b1;

   iopc_io_pad_config #(.HAS_PORT_C_EDGE(HAS_C)) iopc_io_pad_config_inst (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn),
      .padOut(padOut), .padOe_n(padOe_n), .padEdgeRate(padEdgeRate),
      .padRailSel(padRailSel), .wakeUp(wakeUp), .irq(irq));
   iopc_pad_partner iopc_pad_partner_inst (.padOut(padOut),
      .padOe_n(padOe_n), .extLevel(extLevel), .padIn(padIn));

   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         nErrors++;
         finalReport();
      end
   end

   task automatic finalReport();
      if (nErrors == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rdc(logic [7:0] a, logic [7:0] exp);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk("read data", regRdata, exp);
   endtask
   task automatic settle();
      @(posedge mclk);
      #1;
   endtask
   // a pad falls while asleep, then status and irq are inspected
   task automatic wk(int pin, logic [7:0] expSt, logic expIrq);
      wr(OFS_SLEEP, 8'h01);
      extLevel[pin] <= 1'b0;
      settle();
      chk("wake pulse", wakeUp, expSt[IRQ_WAKE]);
      settle();
      chk("wake pulse end", wakeUp, 1'b0);
      @(posedge mclk);
      rdc(OFS_INTSTAT, expSt);
      chk("irq", irq, expIrq);
      rdc(OFS_SLEEP, {7'h00, ~expSt[IRQ_WAKE]});
      wr(OFS_INTSTAT, 8'h01);
      extLevel[pin] <= 1'b1;
      settle();
      chk("irq cleared", irq, 1'b0);
   endtask
   function automatic logic [7:0] edgeExp(logic [7:0] w);
      // port C bits read zero on the small variant
      return HAS_C ? w : (w & 8'hCF);
   endfunction

   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      for (int p = 0; p < NPORT; p++) begin
         rdc(OFS_DATA0 + 8'(p), RST_PORT);
         rdc(OFS_DIR0 + 8'(p), RST_PORT);
      end
      rdc(OFS_EDGE, RST_CFG);
      rdc(OFS_SUPLO, RST_CFG);
      rdc(OFS_SUPHI, RST_CFG);
      for (int k = 0; k < 4; k++) begin
         v = {4{2'(k)}};
         wr(OFS_EDGE, v);
         rdc(OFS_EDGE, edgeExp(v));
         chk("edge pads", padEdgeRate, {4'h0, edgeExp(v)});
      end
      repeat (4) begin
         v = 8'($random(seed));
         wr(OFS_SUPLO, v);
         wr(OFS_SUPHI, ~v);
         rdc(OFS_SUPLO, v);
         rdc(OFS_SUPHI, ~v);
         chk("rail pads", padRailSel, {~v, v});
      end
      rdc(8'h1F, 8'h00);
      wr(OFS_DIR0 + 8'(PB), 8'h00);
      settle();
      chk("B level", padOut[15:8], 8'hFF);
      chk("B enable", padOe_n[15:8], 8'h00);
      v = 8'($random(seed));
      wr(OFS_DATA0, v);
      wr(OFS_DIR0, 8'h0F);
      settle();
      chk("A level", padOut[7:0], v);
      chk("A enable", padOe_n[7:0], 8'h0F);
      wr(OFS_DIR0 + 8'(PE), 8'h00);
      settle();
      chk("E1 enable", padOe_n[33], 1'b1);
      v = 8'($random(seed));
      extLevel[23:16] <= v;
      wr(OFS_BITOP, {2'b00, 3'(PC), 3'h5});
      rdc(OFS_DATA0 + 8'(PC), v & 8'hDF);
      wr(OFS_BITOP, {2'b11, 3'(PA), 3'h6});
      rdc(OFS_DIR0, 8'h4F);
      wr(OFS_INTMASK, 8'h01);
      wr(OFS_WAKEF, 8'h01);
      // nibble enables for D high and E low
      wr(OFS_WAKENIB, 8'h60);
      wk(40, 8'h01, 1'b1);
      wk(41, 8'h00, 1'b0);
      wk(31, 8'h01, 1'b1);
      wk(33, 8'h00, 1'b0);
      // port A pin 6 is an input after the bit op, pin 2 has no enable
      wr(OFS_WAKEA, 8'h40);
      wk(2, 8'h00, 1'b0);
      wk(6, 8'h01, 1'b1);
      wr(OFS_INTMASK, 8'h00);
      wk(40, 8'h01, 1'b0);
      finalReport();
   end
endmodule
